// >>> hdl/dbp_pkg.sv
/*
 * Package for the DRAM bank-closing host controller: register map, command
 * codes, pin-bundle struct and timing figures in cycles of hclk.
 * Assumes a 20 MHz hclk and a device that samples commands on hclk edges.
 */
package dbp_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0]  ADDR_CMD    = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_CFG    = 8'h08;
	localparam logic [7:0]  ADDR_OPEN   = 8'h0C;
	// cmd, cfg and status register fields
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_BANK_LSB = 4;
	localparam int CMD_AB_BIT  = 7;
	localparam int CMD_AP_BIT  = 8;
	localparam int CFG_BL32_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	// ==========================================================
	// operation codes written by software
	typedef enum logic [2:0] {
		DBP_OP_ACT = 3'h1,
		DBP_OP_RD  = 3'h2,
		DBP_OP_WR  = 3'h3,
		DBP_OP_MWR = 3'h4,
		DBP_OP_PRE = 3'h5
	} dbp_op_e;
	// first-cycle command/address codes on the pins, bits [4:0]
	localparam logic [5:0] CA_PRE = 6'h10;
	localparam logic [5:0] CA_ACT = 6'h01;
	localparam logic [5:0] CA_RD  = 6'h02;
	localparam logic [5:0] CA_WR  = 6'h04;
	localparam logic [5:0] CA_MWR = 6'h06;
	localparam int CA_AB_BIT = 5;
	// ==========================================================
	// timing figures in ns, counts derived for 20 MHz
	localparam int TCK_NS    = 50;
	localparam int TRPAB_NS  = 21;
	localparam int TRPPB_NS  = 18;
	localparam int TRAS_NS   = 42;
	localparam int TRCD_NS   = 18;
	localparam int TWR_NS    = 18;
	localparam int TRTP_NS   = 8;
	localparam int WL_CK     = 8;
	localparam int PREFETCH  = 16;
	localparam logic [7:0] N_RPAB = 8'((TRPAB_NS + TCK_NS - 1) / TCK_NS);
	localparam logic [7:0] N_RPPB = 8'((TRPPB_NS + TCK_NS - 1) / TCK_NS);
	localparam logic [7:0] N_RAS  = 8'((TRAS_NS + TCK_NS - 1) / TCK_NS);
	localparam logic [7:0] N_RCD  = 8'((TRCD_NS + TCK_NS - 1) / TCK_NS);
	localparam logic [7:0] N_WR   = 8'((TWR_NS + TCK_NS - 1) / TCK_NS);
	localparam logic [7:0] N_RTP  = 8'((TRTP_NS + TCK_NS - 1) / TCK_NS);
	localparam logic [7:0] N_RC   = N_RAS + N_RPPB;
	localparam logic [7:0] N_B16  = 8'(PREFETCH / 2);
	localparam logic [7:0] N_B32  = 8'(2 * PREFETCH / 2);
	localparam logic [7:0] N_XTRA = 8'h08;
	localparam logic [7:0] N_WL   = 8'(WL_CK);
	localparam logic [7:0] N_ONE  = 8'h01;
	// ==========================================================
	// pins toward the device
	typedef struct packed {
		logic       cs;
		logic [5:0] ca;
	} dbp_pins_s;
	localparam dbp_pins_s PINS_IDLE = '{cs: 1'b0, ca: 6'h00};
endpackage : dbp_pkg

// >>> hdl/dbp_bank_timer.sv
/*
 * Per-bank timing tracker: counts the windows that gate precharge,
 * activate and auto-precharge accesses for one bank of the device.
 * Assumes one-cycle event pulses from the sequencer in the same clock.
 */
`timescale 1ns/100ps
module dbp_bank_timer (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// events for this bank
	input  wire logic       act_i,
	input  wire logic       pre_i,
	input  wire logic       pre_all_i,
	input  wire logic [7:0] pre_hold_i,
	input  wire logic [7:0] auto_dly_i,
	input  wire logic       auto_i,
	// readiness
	output logic            open_o,
	output logic            pre_ok_o,
	output logic            act_ok_o,
	output logic            col_ok_o
);
	logic [7:0] ras_q;
	logic [7:0] rc_q;
	logic [7:0] rp_q;
	logic [7:0] hold_q;
	logic [7:0] auto_q;
	logic       auto_pend_q;
	logic       open_q;

	// ==========================================================
	// row-cycle counters restart on activate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ras_q <= 8'h00;
			rc_q  <= 8'h00;
		end else if (act_i) begin
			ras_q <= dbp_pkg::N_RAS;
			rc_q  <= dbp_pkg::N_RC;
		end else begin
			if (ras_q != 8'h00) ras_q <= ras_q - 8'h01;
			if (rc_q != 8'h00) rc_q <= rc_q - 8'h01;
		end
	end

	// hold off precharge after a column command: read BL/2, write recovery
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_q <= 8'h00;
		end else if (pre_hold_i != 8'h00) begin
			hold_q <= pre_hold_i;
		end else if (hold_q != 8'h00) begin
			hold_q <= hold_q - 8'h01;
		end
	end

	// auto-precharge: wait the burst delay, then also tRAS (lockout)
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			auto_q      <= 8'h00;
			auto_pend_q <= 1'b0;
		end else if (auto_i) begin
			auto_q      <= auto_dly_i;
			auto_pend_q <= 1'b1;
		end else if (auto_pend_q) begin
			if (auto_q != 8'h00) auto_q <= auto_q - 8'h01;
			else if (ras_q == 8'h00) auto_pend_q <= 1'b0;
		end
	end

	// precharge recovery: all-bank and per-bank lengths, both one cycle at 20 MHz
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rp_q <= 8'h00;
		end else if (pre_i) begin
			rp_q <= pre_all_i ? dbp_pkg::N_RPAB : dbp_pkg::N_RPPB;
		end else if (auto_pend_q && auto_q == 8'h00 && ras_q == 8'h00) begin
			rp_q <= dbp_pkg::N_RPPB;
		end else if (rp_q != 8'h00) begin
			rp_q <= rp_q - 8'h01;
		end
	end

	// bank open state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) open_q <= 1'b0;
		else if (act_i) open_q <= 1'b1;
		else if (pre_i || auto_i) open_q <= 1'b0;
	end

	assign open_o   = open_q;
	assign pre_ok_o = (ras_q == 8'h00) && (hold_q == 8'h00) && !auto_pend_q;
	assign act_ok_o = !open_q && (rp_q == 8'h00) && (rc_q == 8'h00) && !auto_pend_q;
	assign col_ok_o = open_q && (rc_q <= dbp_pkg::N_RC - dbp_pkg::N_RCD);

	// assertions
	ras_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
		auto_pend_q && ras_q != 8'h00 |=> auto_pend_q)
		else $error("auto-precharge left before tRAS");
	rp_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pre_i && pre_all_i |=> rp_q == dbp_pkg::N_RPAB)
		else $error("all-bank recovery length wrong");
	act_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pre_i |=> !act_ok_o)
		else $error("activate allowed right after precharge");
endmodule : dbp_bank_timer

// >>> hdl/dbp_ctrl.sv
/*
 * Host controller that issues activate, column and precharge commands to
 * the DRAM and keeps every bank's precharge timing. Software writes one
 * command word over AHB-Lite; the controller waits for legality, sends it.
 * Assumes one AHB-Lite master, hclk shared with the device command clock.
 */
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module dbp_ctrl (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// ahb-lite slave
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata,
	// device command pins
	output dbp_pkg::dbp_pins_s    dram_pins
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CYC1 = 2'b11,
		ST_CYC2 = 2'b10
	} dbp_st_e;

	dbp_st_e            st_q;
	logic [8:0]         cmd_q;
	logic               bl32_q;
	logic               wr_ph_q;
	logic [7:0]         addr_q;
	logic               err_q;
	dbp_pkg::dbp_pins_s pins_q;
	logic [7:0]         open_v;
	logic [7:0]         pre_ok_v;
	logic [7:0]         act_ok_v;
	logic [7:0]         col_ok_v;
	logic [2:0]         op;
	logic [2:0]         bank;
	logic               ab;
	logic               ap;
	logic               legal;
	logic               fire;
	logic [7:0]         bsel;
	logic [7:0]         ev_act;
	logic [7:0]         ev_pre;
	logic [7:0]         ev_auto;
	logic [7:0]         hold_val;
	logic [7:0]         auto_val;
	logic [7:0]         burst;

	assign op    = cmd_q[dbp_pkg::CMD_OP_LSB +: 3];
	assign bank  = cmd_q[dbp_pkg::CMD_BANK_LSB +: 3];
	assign ab    = cmd_q[dbp_pkg::CMD_AB_BIT];
	assign ap    = cmd_q[dbp_pkg::CMD_AP_BIT];
	assign bsel  = 8'h01 << bank;
	assign burst = bl32_q ? dbp_pkg::N_B32 : dbp_pkg::N_B16;

	// ==========================================================
	// ahb-lite slave: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_q <= 1'b0;
			addr_q  <= 8'h00;
		end else if (hready) begin
			wr_ph_q <= hsel && htrans[1] && hwrite;
			addr_q  <= haddr[7:0];
		end
	end

	// command word and config, written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q  <= 9'h000;
			bl32_q <= 1'b0;
		end else if (wr_ph_q) begin
			if (addr_q == dbp_pkg::ADDR_CMD && st_q == ST_IDLE) cmd_q <= hwdata[8:0];
			if (addr_q == dbp_pkg::ADDR_CFG) bl32_q <= hwdata[dbp_pkg::CFG_BL32_BIT];
		end
	end

	// sequencer: a command write while busy is dropped and flagged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q  <= ST_IDLE;
			err_q <= 1'b0;
		end else begin
			if (wr_ph_q && addr_q == dbp_pkg::ADDR_CMD && st_q != ST_IDLE) err_q <= 1'b1;
			else if (wr_ph_q && addr_q == dbp_pkg::ADDR_STATUS && hwdata[dbp_pkg::STAT_ERR_BIT])
				err_q <= 1'b0;
			unique case (st_q)
				ST_IDLE: if (wr_ph_q && addr_q == dbp_pkg::ADDR_CMD) st_q <= ST_WAIT;
				ST_WAIT: if (legal) st_q <= ST_CYC1;
				ST_CYC1: st_q <= ST_CYC2;
				ST_CYC2: st_q <= ST_IDLE;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// legality check per operation
	always_comb begin
		unique case (op)
			dbp_pkg::DBP_OP_ACT: legal = act_ok_v[bank];
			dbp_pkg::DBP_OP_RD,
			dbp_pkg::DBP_OP_WR,
			dbp_pkg::DBP_OP_MWR: legal = col_ok_v[bank];
			dbp_pkg::DBP_OP_PRE: legal = ab ? (&(pre_ok_v | ~open_v)) : pre_ok_v[bank];
			default:             legal = 1'b1;
		endcase
	end
	assign fire = (st_q == ST_CYC1);

	// pins: first cycle carries the op and flag, second the bank
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins_q <= dbp_pkg::PINS_IDLE;
		end else if (st_q == ST_WAIT && legal) begin
			pins_q.cs <= 1'b1;
			unique case (op)
				dbp_pkg::DBP_OP_ACT: pins_q.ca <= dbp_pkg::CA_ACT;
				dbp_pkg::DBP_OP_RD:  pins_q.ca <= dbp_pkg::CA_RD | {ap, 5'h00};
				dbp_pkg::DBP_OP_WR:  pins_q.ca <= dbp_pkg::CA_WR | {ap, 5'h00};
				dbp_pkg::DBP_OP_MWR: pins_q.ca <= dbp_pkg::CA_MWR | {ap, 5'h00};
				dbp_pkg::DBP_OP_PRE: pins_q.ca <= dbp_pkg::CA_PRE | {ab, 5'h00};
				default:             pins_q.ca <= 6'h00;
			endcase
		end else if (st_q == ST_CYC1) begin
			pins_q.cs <= 1'b0;
			pins_q.ca <= {3'h0, bank};
		end else begin
			pins_q <= dbp_pkg::PINS_IDLE;
		end
	end
	assign dram_pins = pins_q;

	// ==========================================================
	// per-bank events and the delays that go with them
	always_comb begin
		ev_act   = 8'h00;
		ev_pre   = 8'h00;
		ev_auto  = 8'h00;
		hold_val = 8'h00;
		auto_val = 8'h00;
		if (fire) begin
			unique case (op)
				dbp_pkg::DBP_OP_ACT: ev_act = bsel;
				dbp_pkg::DBP_OP_PRE: ev_pre = ab ? 8'hFF : bsel;
				dbp_pkg::DBP_OP_RD: begin
					// never before BL/2, nor before tRTP counted from BL/2 - 8
					hold_val = (dbp_pkg::N_RTP > dbp_pkg::N_XTRA) ?
					           burst - dbp_pkg::N_XTRA + dbp_pkg::N_RTP : burst;
					auto_val = bl32_q ? dbp_pkg::N_XTRA + dbp_pkg::N_RTP
					                  : dbp_pkg::N_RTP;
					ev_auto  = ap ? bsel : 8'h00;
				end
				dbp_pkg::DBP_OP_WR,
				dbp_pkg::DBP_OP_MWR: begin
					// prefetch group of 16 must finish before recovery starts
					hold_val = dbp_pkg::N_WL + burst + dbp_pkg::N_ONE + dbp_pkg::N_WR;
					auto_val = hold_val;
					ev_auto  = ap ? bsel : 8'h00;
				end
				default: ev_act = 8'h00;
			endcase
		end
	end

	// one timer for each of the eight banks
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_bank
			dbp_bank_timer u_tmr (
				.hclk       (hclk),
				.hresetn    (hresetn),
				.act_i      (ev_act[gi]),
				.pre_i      (ev_pre[gi]),
				.pre_all_i  (ab),
				.pre_hold_i (bsel[gi] && fire ? hold_val : 8'h00),
				.auto_dly_i (auto_val),
				.auto_i     (ev_auto[gi]),
				.open_o     (open_v[gi]),
				.pre_ok_o   (pre_ok_v[gi]),
				.act_ok_o   (act_ok_v[gi]),
				.col_ok_o   (col_ok_v[gi])
			);
		end
	endgenerate

	// ==========================================================
	// read data from flip-flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				dbp_pkg::ADDR_CMD:    hrdata <= {23'h0, cmd_q};
				dbp_pkg::ADDR_STATUS: hrdata <= {30'h0, err_q, st_q != ST_IDLE};
				dbp_pkg::ADDR_CFG:    hrdata <= {31'h0, bl32_q};
				dbp_pkg::ADDR_OPEN:   hrdata <= {24'h0, open_v};
				default:              hrdata <= 32'h0000_0000;
			endcase
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// assertions
	sequence pre_sent_s;
		st_q == ST_WAIT && legal && op == dbp_pkg::DBP_OP_PRE;
	endsequence
	pre_ab_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pre_sent_s |=> pins_q.cs && pins_q.ca[dbp_pkg::CA_AB_BIT] == $past(ab))
		else $error("all-bank flag not on first cycle");
	pre_bank_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pre_sent_s ##1 1'b1 |=> !pins_q.cs && pins_q.ca[2:0] == $past(bank, 2))
		else $error("bank select missing on second cycle");
	all_close_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fire && op == dbp_pkg::DBP_OP_PRE && ab |=> open_v == 8'h00)
		else $error("all-bank precharge left a bank open");
	ap_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == ST_WAIT && legal && op == dbp_pkg::DBP_OP_RD |=> pins_q.ca[5] == ap)
		else $error("auto-precharge bit wrong on read");
	act_gate_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fire && op == dbp_pkg::DBP_OP_ACT |=> !act_ok_v[$past(bank)])
		else $error("bank ready right after activate");
	cmd_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == ST_CYC1 |=> st_q == ST_CYC2 ##1 st_q == ST_IDLE)
		else $error("command not two cycles");
	ap_close_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fire && ap && op == dbp_pkg::DBP_OP_WR |=> !open_v[$past(bank)])
		else $error("auto-precharge left bank open");
	hold_pre_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fire && op == dbp_pkg::DBP_OP_WR |=> !pre_ok_v[$past(bank)])
		else $error("precharge allowed right after write");
endmodule : dbp_ctrl

// >>> tb/dbp_dram_model.sv
/*
 * Behavioural model of the eight-bank DRAM on the controller's command pins:
 * decodes two-cycle commands, keeps bank state and counts timing breaches.
 * Assumes commands are sampled on rising hclk and bl32 mirrors the CFG value.
 */
`timescale 1ns/100ps
module dbp_dram_model (
	// clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// command pins and burst length
	input  wire dbp_pkg::dbp_pins_s pins,
	input  wire logic          bl32,
	// observation
	output logic [7:0]         open_q,
	output logic [5:0]         last_ca_q,
	output logic [2:0]         last_bank_q,
	output int                 cmd_cnt_q,
	output int                 viol_q
);
	localparam int RAS = int'(dbp_pkg::N_RAS);
	localparam int RCD = int'(dbp_pkg::N_RCD);
	localparam int RTP = int'(dbp_pkg::N_RTP);
	localparam int WRC = int'(dbp_pkg::N_WR);
	localparam int RC  = int'(dbp_pkg::N_RC);
	localparam int WL  = int'(dbp_pkg::N_WL);
	int act_t [8];
	int pre_t [8];
	int rd_t  [8];
	int wr_t  [8];
	int rp_n  [8];
	int cyc, t1, s, bl2;
	logic pend;
	logic [5:0] ca1;
	// =================================================
	// bank bookkeeping
	task automatic close_bank(input int i, input int at, input int rp);
		open_q[i] = 1'b0;
		pre_t[i] = at;
		rp_n[i] = rp;
	endtask : close_bank
	// precharge legality; a closed bank skips these checks, but close_bank still restarts its recovery time
	task automatic pre_chk(input int i);
		if (open_q[i] && (t1 - act_t[i] < RAS)) viol_q++;
		if (open_q[i] && (t1 - rd_t[i] < ((RTP > 8) ? bl2 - 8 + RTP : bl2))) viol_q++;
		if (open_q[i] && (t1 - wr_t[i] < WL + bl2 + 1 + WRC)) viol_q++;
	endtask : pre_chk
	task automatic decode(input int b);
		bl2 = bl32 ? 16 : 8;
		last_ca_q = ca1;
		last_bank_q = 3'(b);
		cmd_cnt_q++;
		if (ca1[4:0] == dbp_pkg::CA_PRE[4:0]) begin
			if (ca1[5]) begin
				// all banks, bank bits ignored, same one-cycle recovery as per-bank at 20 MHz
				for (int i = 0; i < 8; i++) begin
					pre_chk(i);
					close_bank(i, t1, int'(dbp_pkg::N_RPAB));
				end
			end else begin
				pre_chk(b);
				close_bank(b, t1, int'(dbp_pkg::N_RPPB));
			end
		end else if (ca1[4:0] == dbp_pkg::CA_ACT[4:0]) begin
			if (open_q[b]) viol_q++;
			if (t1 - pre_t[b] < rp_n[b]) viol_q++;
			if (t1 - act_t[b] < RC) viol_q++;
			open_q[b] = 1'b1;
			act_t[b] = t1;
		end else if (ca1[4:0] == dbp_pkg::CA_RD[4:0] || ca1[4:0] == dbp_pkg::CA_WR[4:0] ||
			     ca1[4:0] == dbp_pkg::CA_MWR[4:0]) begin
			if (!open_q[b] || (t1 - act_t[b] < RCD)) viol_q++;
			if (ca1[4:0] == dbp_pkg::CA_RD[4:0]) begin
				rd_t[b] = t1;
				s = t1 + (bl32 ? 8 : 0) + RTP;
			end else begin
				wr_t[b] = t1;
				s = t1 + WL + bl2 + 1 + WRC;
			end
			if (s < act_t[b] + RAS) s = act_t[b] + RAS;
			// low flag leaves the bank open, high closes it internally
			if (ca1[5]) close_bank(b, s, int'(dbp_pkg::N_RPPB));
		end else begin
			viol_q++;
		end
	endtask : decode
	// =================================================
	// command capture: first cycle code, second cycle bank
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 8; i++) begin
				act_t[i] = -1000;
				pre_t[i] = -1000;
				rd_t[i] = -1000;
				wr_t[i] = -1000;
				rp_n[i] = 0;
			end
			open_q = 8'h00;
			last_ca_q = 6'h00;
			last_bank_q = 3'h0;
			cmd_cnt_q = 0;
			viol_q = 0;
			cyc = 0;
			pend = 1'b0;
		end else begin
			cyc++;
			if (pend) begin
				pend = 1'b0;
				decode(int'(pins.ca[2:0]));
			end
			if (pins.cs === 1'b1) begin
				ca1 = pins.ca;
				t1 = cyc;
				pend = 1'b1;
			end
		end
	end
endmodule : dbp_dram_model

// >>> tb/test_dbp_ctrl.sv
/*
 * Self-checking bench for the bank-closing controller: drives AHB-Lite,
 * issues commands, checks registers and the device model's observations.
 * Assumes hreadyout is fed back as hready and the model sees dram_pins.
 */
`timescale 1ns/100ps
module test_dbp_ctrl;
	logic               hclk, hresetn, hsel, hwrite, bl32;
	logic [31:0]        haddr, hwdata;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	wire logic          hreadyout, hresp;
	wire logic [31:0]   hrdata;
	dbp_pkg::dbp_pins_s dram_pins;
	logic [7:0]         m_open;
	logic [5:0]         m_ca;
	logic [2:0]         m_bank;
	int                 m_cnt, m_viol, errors, samples_checked;
	dbp_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.dram_pins(dram_pins));
	dbp_dram_model i_mem (.hclk(hclk), .hresetn(hresetn), .pins(dram_pins), .bl32(bl32),
		.open_q(m_open), .last_ca_q(m_ca), .last_bank_q(m_bank), .cmd_cnt_q(m_cnt),
		.viol_q(m_viol));
	// =================================================
	// checking and bus helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		if (errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	// address phase held until hready, then data phase until hready
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
			   output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk(32'(hresp), 32'h0);
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, {24'h0, a}, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		ahb(1'b0, {24'h0, a}, 32'h0, q);
	endtask : rd
	task automatic wait_idle();
		logic [31:0] q;
		q = 32'h1;
		for (int i = 0; i < 300 && q[0] !== 1'b0; i++) rd(dbp_pkg::ADDR_STATUS, q);
		chk(32'(q[0]), 32'h0);
		repeat (2) @(posedge hclk);
	endtask : wait_idle
	task automatic send(input dbp_pkg::dbp_op_e op, input logic [2:0] b, input logic ab,
			    input logic ap);
		logic [5:0] e;
		int n0;
		n0 = m_cnt;
		case (op)
			dbp_pkg::DBP_OP_ACT: e = dbp_pkg::CA_ACT;
			dbp_pkg::DBP_OP_RD:  e = dbp_pkg::CA_RD;
			dbp_pkg::DBP_OP_WR:  e = dbp_pkg::CA_WR;
			dbp_pkg::DBP_OP_MWR: e = dbp_pkg::CA_MWR;
			default:             e = dbp_pkg::CA_PRE;
		endcase
		e[5] = (op == dbp_pkg::DBP_OP_PRE) ? ab : ap;
		wr(dbp_pkg::ADDR_CMD, {23'h0, ap, ab, b, 1'b0, op});
		wait_idle();
		chk(32'(m_cnt - n0), 32'h1);
		chk({26'h0, m_ca}, {26'h0, e});
		if (!ab) chk({29'h0, m_bank}, {29'h0, b});
	endtask : send
	// lets any scheduled internal precharge start before reading the mask
	task automatic chk_open(input logic [7:0] e);
		logic [31:0] q;
		repeat (40) @(posedge hclk);
		rd(dbp_pkg::ADDR_OPEN, q);
		chk(q, {24'h0, e});
		chk({24'h0, m_open}, {24'h0, e});
		chk(32'(m_viol), 32'h0);
	endtask : chk_open
	// =================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] q;
		rd(dbp_pkg::ADDR_STATUS, q);
		chk(q, 32'h0);
		rd(dbp_pkg::ADDR_CFG, q);
		chk(q, 32'h0);
		rd(dbp_pkg::ADDR_OPEN, q);
		chk(q, 32'h0);
		rd(8'h10, q);
		chk(q, 32'h0);
	endtask : t_reset
	// every bank: open, read, check it stays open, close, reopen, close
	task automatic t_banks();
		for (int b = 0; b < 8; b++) begin
			send(dbp_pkg::DBP_OP_ACT, 3'(b), 1'b0, 1'b0);
			send(dbp_pkg::DBP_OP_RD, 3'(b), 1'b0, 1'b0);
			chk_open(8'h01 << b);
			send(dbp_pkg::DBP_OP_PRE, 3'(b), 1'b0, 1'b0);
			send(dbp_pkg::DBP_OP_ACT, 3'(b), 1'b0, 1'b0);
			send(dbp_pkg::DBP_OP_PRE, 3'(b), 1'b0, 1'b0);
			chk_open(8'h00);
		end
	endtask : t_banks
	task automatic t_all();
		send(dbp_pkg::DBP_OP_ACT, 3'h0, 1'b0, 1'b0);
		send(dbp_pkg::DBP_OP_ACT, 3'h5, 1'b0, 1'b0);
		send(dbp_pkg::DBP_OP_ACT, 3'h7, 1'b0, 1'b0);
		chk_open(8'hA1);
		send(dbp_pkg::DBP_OP_PRE, 3'h2, 1'b1, 1'b0);
		chk_open(8'h00);
		send(dbp_pkg::DBP_OP_ACT, 3'h5, 1'b0, 1'b0);
		send(dbp_pkg::DBP_OP_PRE, 3'h5, 1'b0, 1'b0);
		chk_open(8'h00);
		// precharge queued straight behind a read: must wait out BL/2
		send(dbp_pkg::DBP_OP_ACT, 3'h3, 1'b0, 1'b0);
		send(dbp_pkg::DBP_OP_RD, 3'h3, 1'b0, 1'b0);
		send(dbp_pkg::DBP_OP_PRE, 3'h3, 1'b0, 1'b0);
		chk_open(8'h00);
	endtask : t_all
	// each column op with and without auto-precharge, both burst lengths
	task automatic t_auto();
		dbp_pkg::dbp_op_e oa [3];
		logic [31:0] q;
		oa = '{dbp_pkg::DBP_OP_RD, dbp_pkg::DBP_OP_WR, dbp_pkg::DBP_OP_MWR};
		for (int l = 0; l < 2; l++) begin
			wr(dbp_pkg::ADDR_CFG, 32'(l));
			bl32 <= 1'(l);
			rd(dbp_pkg::ADDR_CFG, q);
			chk(q, 32'(l));
			for (int k = 0; k < 3; k++) begin
				send(dbp_pkg::DBP_OP_ACT, 3'h1, 1'b0, 1'b0);
				send(oa[k], 3'h1, 1'b0, 1'b1);
				chk_open(8'h00);
				send(dbp_pkg::DBP_OP_ACT, 3'h1, 1'b0, 1'b0);
				send(oa[k], 3'h1, 1'b0, 1'b0);
				chk_open(8'h02);
				send(dbp_pkg::DBP_OP_PRE, 3'h1, 1'b0, 1'b0);
				chk_open(8'h00);
			end
		end
		wr(dbp_pkg::ADDR_CFG, 32'h0);
		bl32 <= 1'b0;
	endtask : t_auto
	// second command while the precharge still waits out write recovery
	task automatic t_refuse();
		logic [31:0] q;
		int n0;
		send(dbp_pkg::DBP_OP_ACT, 3'h6, 1'b0, 1'b0);
		send(dbp_pkg::DBP_OP_WR, 3'h6, 1'b0, 1'b0);
		n0 = m_cnt;
		wr(dbp_pkg::ADDR_CMD, {23'h0, 1'b0, 1'b0, 3'h6, 1'b0, dbp_pkg::DBP_OP_PRE});
		wr(dbp_pkg::ADDR_CMD, {23'h0, 1'b0, 1'b0, 3'h0, 1'b0, dbp_pkg::DBP_OP_ACT});
		wait_idle();
		rd(dbp_pkg::ADDR_STATUS, q);
		chk(q, 32'h2);
		rd(dbp_pkg::ADDR_CMD, q);
		chk(q, {23'h0, 1'b0, 1'b0, 3'h6, 1'b0, dbp_pkg::DBP_OP_PRE});
		chk(32'(m_cnt - n0), 32'h1);
		wr(dbp_pkg::ADDR_STATUS, 32'h2);
		rd(dbp_pkg::ADDR_STATUS, q);
		chk(q, 32'h0);
		chk_open(8'h00);
	endtask : t_refuse
	// =================================================
	// clock, main sequence and watchdog
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		bl32 = 1'b0;
		errors = 0;
		samples_checked = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_banks();
		t_all();
		t_auto();
		t_refuse();
		give_verdict();
	end
	initial begin
		repeat (40000) @(posedge hclk);
		errors++;
		give_verdict();
	end
endmodule : test_dbp_ctrl
